// ===== core/dmati_core.sv
// Chosen here: the placing of the registers and the address-and-strobe port.
`timescale 1ns/100ps
module dmati_core
   import dmati_pkg::*;
(
   // clock and reset
   input  wire logic        sys_clk,
   input  wire logic        reset,
   // register port
   input  wire dmati_bus_t  bus,
   output logic [7:0]       rdata,
   // serial channel side
   input  wire dmati_chan_t chan,
   // memory cycle strobe, progress and channel priority
   output logic             mem_cycle,
   output logic             xfer_done,
   output logic [1:0]       chan_prio,
   // interrupts
   output logic             dma_error_irq,
   output logic             dma_normal_end_irq
);
   // ==========================================================
   // registers
   logic [7:0]   irq_en_q;
   logic [7:0]   mode_q;
   logic [7:0]   ctrl_q;
   logic [7:0]   cda_q;
   logic [7:0]   eda_q;
   logic [7:0]   bfl_q;
   logic [3:0]   fct_q;
   logic         de_q;
   logic         eot_q, eom_q, bof_q, cof_q;
   logic [7:0]   cnt_q;
   dmati_state_t state_q;
   logic         started_q;
   logic         tmr_start, tmr_busy, tmr_done;
   logic [5:0]   tmr_len;

   function automatic logic wr_to(input dmati_bus_t b, input logic [3:0] a);
      wr_to = b.wr && (b.addr == a);
   endfunction

   wire chained  = mode_q[DMATI_MD_TMOD];
   wire byte_bus = (ctrl_q[1:0] == DMATI_BUS_BYTE);
   wire rx_dir   = ctrl_q[DMATI_CT_DIR];
   wire st_wr    = wr_to(bus, DMATI_ADDR_STATUS);
   wire abort    = wr_to(bus, DMATI_ADDR_COMMAND) && bus.wdata == DMATI_CMD_ABORT;
   wire fct_clr  = wr_to(bus, DMATI_ADDR_COMMAND) && bus.wdata == DMATI_CMD_FCT_CLEAR;
   wire cnt_en   = mode_q[DMATI_MD_CNTE];
   wire req_ok   = chan.xfer_req && (eda_q != cda_q);
   // a done that lands while suspended is held by the timer until resume
   wire tmr_fire = tmr_done && de_q;
   wire overrun  = de_q && chained && rx_dir && chan.xfer_req && (eda_q == cda_q)
                   && (state_q == DMATI_XFER || state_q == DMATI_SWTCH);
   wire last_cyc = tmr_fire && state_q == DMATI_XFER;
   wire buf_end  = last_cyc && (cnt_q == 8'h01);
   wire frm_end  = last_cyc && chan.frame_end;
   wire all_done = last_cyc && (chained ? (frm_end && (!mode_q[DMATI_MD_NF] || chan.last_buf))
                                        : (cnt_q == 8'h01));

   function automatic logic [5:0] setup_len(input logic bb, input logic rx);
      if (bb) setup_len = rx ? DMATI_RX_SETUP_B : DMATI_TX_SETUP_B;
      else    setup_len = rx ? DMATI_RX_SETUP_W : DMATI_TX_SETUP_W;
   endfunction

   function automatic logic [5:0] sw_len(input logic bb, input logic rx, input logic fe);
      if (bb) sw_len = rx ? DMATI_RX_SW_B : (fe ? DMATI_TX_SW_END_B : DMATI_TX_SW_MID_B);
      else    sw_len = rx ? DMATI_RX_SW_W : (fe ? DMATI_TX_SW_END_W : DMATI_TX_SW_MID_W);
   endfunction

   // ==========================================================
   // state counter
   dmati_timer dmati_timer_i (
      .sys_clk (sys_clk),
      .reset   (reset),
      .start   (tmr_start),
      .len     (tmr_len),
      .hold    (!de_q),
      .busy    (tmr_busy),
      .done    (tmr_done)
   );

   always_comb begin
      tmr_start = 1'b0;
      tmr_len   = DMATI_XFER_STATES;
      case (state_q)
         DMATI_IDLE: begin
            if (de_q && chained) begin
               tmr_start = 1'b1;
               tmr_len   = setup_len(byte_bus, rx_dir);
            end else if (de_q && req_ok) begin
               tmr_start = 1'b1;
            end
         end
         DMATI_SETUP, DMATI_SWTCH: begin
            if (!tmr_busy && de_q && req_ok) tmr_start = 1'b1;
         end
         DMATI_XFER: begin
            if (all_done || abort) begin
               tmr_start = 1'b0;
            end else if (chained && (buf_end || frm_end)) begin
               tmr_start = 1'b1;
               tmr_len   = sw_len(byte_bus, rx_dir, frm_end);
            end else if (!tmr_busy && de_q && req_ok) begin
               tmr_start = 1'b1;
            end
         end
         DMATI_HALT: tmr_start = 1'b0;
         default:    tmr_start = 1'b0;
      endcase
   end

   // ==========================================================
   // sequencer; a cleared enable freezes the timer and with it the state
   always_ff @(posedge sys_clk) begin
      if (reset) begin
         state_q <= DMATI_IDLE;
      end else if (abort) begin
         state_q <= DMATI_IDLE;
      end else begin
         case (state_q)
            DMATI_IDLE:  if (tmr_start) state_q <= chained ? DMATI_SETUP : DMATI_XFER;
            DMATI_SETUP: if (tmr_start) state_q <= DMATI_XFER;
            DMATI_SWTCH: if (tmr_start) state_q <= DMATI_XFER;
            DMATI_XFER: begin
               if (all_done) state_q <= DMATI_HALT;
               else if (tmr_start && tmr_len != DMATI_XFER_STATES) state_q <= DMATI_SWTCH;
            end
            DMATI_HALT:  if (de_q && !started_q) state_q <= DMATI_IDLE;
            default:     state_q <= DMATI_IDLE;
         endcase
      end
   end

   // completion needs no abort: halt returns to initial once re-enabled
   always_ff @(posedge sys_clk) begin
      if (reset) started_q <= 1'b0;
      else if (state_q == DMATI_HALT && !de_q) started_q <= 1'b0;
      else if (state_q == DMATI_IDLE) started_q <= 1'b1;
   end

   always_ff @(posedge sys_clk) begin
      if (reset) begin
         cnt_q <= 8'h00;
      end else if (tmr_start && tmr_len != DMATI_XFER_STATES) begin
         cnt_q <= bfl_q;
      end else if (state_q == DMATI_IDLE && !chained) begin
         cnt_q <= bfl_q;
      end else if (last_cyc) begin
         cnt_q <= cnt_q - 8'h01;
      end
   end

   // ==========================================================
   // enable bit
   always_ff @(posedge sys_clk) begin
      if (reset) de_q <= 1'b0;
      else if (all_done) de_q <= 1'b0;
      else if (st_wr && bus.wdata[DMATI_ST_DWE]) de_q <= bus.wdata[DMATI_ST_DE];
   end

   // ==========================================================
   // control registers
   always_ff @(posedge sys_clk) begin
      if (reset) begin
         irq_en_q <= 8'h00;
         mode_q   <= 8'h00;
         ctrl_q   <= 8'h00;
      end else begin
         if (wr_to(bus, DMATI_ADDR_IRQ_EN)) irq_en_q <= bus.wdata;
         if (wr_to(bus, DMATI_ADDR_MODE))   mode_q   <= bus.wdata;
         if (wr_to(bus, DMATI_ADDR_CTRL))   ctrl_q   <= bus.wdata;
      end
   end

   // address registers are left unreset on purpose
   always_ff @(posedge sys_clk) begin
      if (wr_to(bus, DMATI_ADDR_CDA)) cda_q <= bus.wdata;
      else if (tmr_start && state_q == DMATI_XFER && tmr_len != DMATI_XFER_STATES) cda_q <= cda_q + 8'h01;
      if (wr_to(bus, DMATI_ADDR_EDA)) eda_q <= bus.wdata;
      if (wr_to(bus, DMATI_ADDR_BFL)) bfl_q <= bus.wdata;
   end

   // ==========================================================
   // frame end counter; wraps from max to zero, set beats clear
   always_ff @(posedge sys_clk) begin
      if (reset) fct_q <= DMATI_FCT_ZERO;
      else if (cnt_en && frm_end && fct_q != DMATI_FCT_MAX) fct_q <= fct_q + 4'h1;
      else if (cnt_en && frm_end) fct_q <= DMATI_FCT_ZERO;
      else if (fct_clr && fct_q != DMATI_FCT_ZERO) fct_q <= fct_q - 4'h1;
   end

   // ==========================================================
   // status flags; hardware set wins over write-one clear
   always_ff @(posedge sys_clk) begin
      if (reset) begin
         eot_q <= 1'b0;
         eom_q <= 1'b0;
         bof_q <= 1'b0;
         cof_q <= 1'b0;
      end else begin
         if (all_done) eot_q <= 1'b1;
         else if (st_wr && bus.wdata[DMATI_ST_EOT]) eot_q <= 1'b0;
         if (frm_end && chained) eom_q <= 1'b1;
         else if (cnt_en && fct_q != DMATI_FCT_ZERO) eom_q <= 1'b1;
         else if (st_wr && bus.wdata[DMATI_ST_EOM]) eom_q <= 1'b0;
         if (overrun) bof_q <= 1'b1;
         else if (st_wr && bus.wdata[DMATI_ST_BOF]) bof_q <= 1'b0;
         if (cnt_en && frm_end && fct_q == DMATI_FCT_MAX) cof_q <= 1'b1;
         else if (st_wr && bus.wdata[DMATI_ST_COF]) cof_q <= 1'b0;
      end
   end

   // ==========================================================
   // outputs; requests ignore state so they persist when idle
   always_ff @(posedge sys_clk) begin
      if (reset) begin
         dma_error_irq      <= 1'b0;
         dma_normal_end_irq <= 1'b0;
         mem_cycle          <= 1'b0;
         xfer_done          <= 1'b0;
         chan_prio          <= DMATI_PRIO_RESET;
      end else begin
         dma_error_irq      <= (cof_q && irq_en_q[DMATI_ST_COF]) || (bof_q && irq_en_q[DMATI_ST_BOF]);
         dma_normal_end_irq <= (eom_q && irq_en_q[DMATI_ST_EOM]) || (eot_q && irq_en_q[DMATI_ST_EOT]);
         mem_cycle          <= last_cyc;
         xfer_done          <= all_done;
         chan_prio          <= DMATI_PRIO_RESET;
      end
   end

   // ==========================================================
   // read port
   always_ff @(posedge sys_clk) begin
      if (reset) begin
         rdata <= 8'h00;
      end else if (bus.rd) begin
         case (bus.addr)
            DMATI_ADDR_STATUS: rdata <= {eot_q, eom_q, bof_q, cof_q, 2'b00, de_q, 1'b0};
            DMATI_ADDR_IRQ_EN: rdata <= irq_en_q;
            DMATI_ADDR_MODE:   rdata <= mode_q;
            DMATI_ADDR_FCT:    rdata <= {4'h0, fct_q};
            DMATI_ADDR_CDA:    rdata <= cda_q;
            DMATI_ADDR_EDA:    rdata <= eda_q;
            DMATI_ADDR_BFL:    rdata <= bfl_q;
            DMATI_ADDR_CTRL:   rdata <= ctrl_q;
            default:           rdata <= 8'h00;
         endcase
      end else begin
         rdata <= 8'h00;
      end
   end

   // ==========================================================
   // checks; long waits are counted here, not unrolled
   logic [5:0] su_age_q;
   logic       su_run_q;
   wire        su_go = state_q == DMATI_IDLE && tmr_start && chained && !byte_bus && !rx_dir;

   // a suspend or abort during set-up voids the measurement
   always_ff @(posedge sys_clk) begin
      if (reset) begin
         su_run_q <= 1'b0;
         su_age_q <= 6'h00;
      end else if (su_go) begin
         su_run_q <= 1'b1;
         su_age_q <= 6'h01;
      end else if (su_run_q && (abort || !de_q || su_age_q == DMATI_TX_SETUP_W)) begin
         su_run_q <= 1'b0;
      end else if (su_run_q) begin
         su_age_q <= su_age_q + 6'h01;
      end
   end

   sequence setup_seq;
      su_run_q && su_age_q == DMATI_TX_SETUP_W;
   endsequence

   sequence frame_mid_seq;
      chained && frm_end && !all_done && !abort;
   endsequence

   sequence halt_end_seq;
      state_q == DMATI_HALT && eot_q && irq_en_q[DMATI_ST_EOT];
   endsequence

   tx_setup_a: assert property (@(posedge sys_clk) disable iff (reset)
      setup_seq |-> tmr_done)
      else $error("transmit setup not 20 states");
   xfer_len_a: assert property (@(posedge sys_clk) disable iff (reset)
      (state_q == DMATI_XFER && tmr_start && tmr_len == DMATI_XFER_STATES) ##1 de_q [*2] |-> ##1 tmr_done)
      else $error("data cycle not 3 states");
   err_irq_a: assert property (@(posedge sys_clk) disable iff (reset)
      dma_error_irq == $past((cof_q && irq_en_q[DMATI_ST_COF]) || (bof_q && irq_en_q[DMATI_ST_BOF])))
      else $error("error request mismatch");
   eot_set_a: assert property (@(posedge sys_clk) disable iff (reset)
      all_done |=> eot_q && !de_q)
      else $error("end of transfer not flagged");
   cof_set_a: assert property (@(posedge sys_clk) disable iff (reset)
      (cnt_en && frm_end && fct_q == DMATI_FCT_MAX) |=> cof_q && fct_q == DMATI_FCT_ZERO)
      else $error("overflow not flagged");
   bof_set_a: assert property (@(posedge sys_clk) disable iff (reset)
      overrun |=> bof_q)
      else $error("overrun not flagged");
   eom_hold_a: assert property (@(posedge sys_clk) disable iff (reset)
      (cnt_en && fct_q != DMATI_FCT_ZERO) |=> eom_q)
      else $error("frame flag dropped with count");
   suspend_a: assert property (@(posedge sys_clk) disable iff (reset)
      (!de_q && !abort && state_q != DMATI_IDLE) |=> $stable(state_q))
      else $error("state moved while suspended");
   prio_a: assert property (@(posedge sys_clk) disable iff (reset)
      chan_prio == DMATI_PRIO_RESET)
      else $error("priority not fixed");
   multi_run_a: assert property (@(posedge sys_clk) disable iff (reset)
      frame_mid_seq |=> state_q == DMATI_SWTCH)
      else $error("frame end stopped a multi-frame run");
   irq_hold_a: assert property (@(posedge sys_clk) disable iff (reset)
      halt_end_seq |=> dma_normal_end_irq)
      else $error("request dropped in halt");
   rst_clear_a: assert property (@(posedge sys_clk) disable iff (reset)
      $past(reset) |-> !chained && !cnt_en && fct_q == DMATI_FCT_ZERO && irq_en_q == 8'h00
                       && !eot_q && !eom_q && !bof_q && !cof_q && !de_q)
      else $error("reset left mode, flags or counter set");
   rst_idle_a: assert property (@(posedge sys_clk) disable iff (reset)
      $past(reset) |-> state_q == DMATI_IDLE)
      else $error("reset did not give initial state");
endmodule

// ===== core/dmati_pkg.sv
package dmati_pkg;
   // ==========================================================
   // register offsets (word addresses on the plain port)
   localparam logic [3:0] DMATI_ADDR_STATUS  = 4'h0;
   localparam logic [3:0] DMATI_ADDR_IRQ_EN  = 4'h1;
   localparam logic [3:0] DMATI_ADDR_MODE    = 4'h2;
   localparam logic [3:0] DMATI_ADDR_COMMAND = 4'h3;
   localparam logic [3:0] DMATI_ADDR_FCT     = 4'h4;
   localparam logic [3:0] DMATI_ADDR_CDA     = 4'h5;
   localparam logic [3:0] DMATI_ADDR_EDA     = 4'h6;
   localparam logic [3:0] DMATI_ADDR_BFL     = 4'h7;
   localparam logic [3:0] DMATI_ADDR_CTRL    = 4'h8;
   // ==========================================================
   // status register fields
   localparam int DMATI_ST_EOT = 7;
   localparam int DMATI_ST_EOM = 6;
   localparam int DMATI_ST_BOF = 5;
   localparam int DMATI_ST_COF = 4;
   localparam int DMATI_ST_DE  = 1;
   localparam int DMATI_ST_DWE = 0;
   // mode register fields
   localparam int DMATI_MD_TMOD = 4;
   localparam int DMATI_MD_NF   = 2;
   localparam int DMATI_MD_CNTE = 1;
   // command register codes
   localparam logic [7:0] DMATI_CMD_ABORT     = 8'h01;
   localparam logic [7:0] DMATI_CMD_FCT_CLEAR = 8'h02;
   // ctrl register fields (bus mode, direction)
   localparam int DMATI_CT_DIR = 2;
   // ==========================================================
   // timing in states, bus mode code, counter limits and reset priority
   localparam logic [5:0] DMATI_XFER_STATES = 6'h03;
   localparam logic [5:0] DMATI_TX_SETUP_W  = 6'h14;
   localparam logic [5:0] DMATI_TX_SW_MID_W = 6'h15;
   localparam logic [5:0] DMATI_TX_SW_END_W = 6'h19;
   localparam logic [5:0] DMATI_RX_SETUP_W  = 6'h12;
   localparam logic [5:0] DMATI_RX_SW_W     = 6'h1A;
   localparam logic [5:0] DMATI_TX_SETUP_B  = 6'h20;
   localparam logic [5:0] DMATI_TX_SW_MID_B = 6'h21;
   localparam logic [5:0] DMATI_TX_SW_END_B = 6'h25;
   localparam logic [5:0] DMATI_RX_SETUP_B  = 6'h17;
   localparam logic [5:0] DMATI_RX_SW_B     = 6'h22;
   localparam logic [1:0] DMATI_BUS_BYTE    = 2'h1;
   localparam logic [3:0] DMATI_FCT_MAX     = 4'hF;
   localparam logic [3:0] DMATI_FCT_ZERO    = 4'h0;
   localparam logic [1:0] DMATI_PRIO_RESET  = 2'h0;

   typedef struct packed {
      logic [3:0] addr;
      logic [7:0] wdata;
      logic       wr;
      logic       rd;
   } dmati_bus_t;

   typedef struct packed {
      logic       xfer_req;
      logic       frame_end;
      logic       last_buf;
   } dmati_chan_t;

   typedef enum logic [4:0] {
      DMATI_IDLE  = 5'b00001,
      DMATI_SETUP = 5'b00010,
      DMATI_XFER  = 5'b00100,
      DMATI_SWTCH = 5'b01000,
      DMATI_HALT  = 5'b10000
   } dmati_state_t;
endpackage

// ===== core/dmati_timer.sv
`timescale 1ns/100ps
// ==========================================================
// state counter: pulses done after len states
module dmati_timer
   import dmati_pkg::*;
(
   // clock and reset
   input  wire logic       sys_clk,
   input  wire logic       reset,
   // control
   input  wire logic       start,
   input  wire logic [5:0] len,
   input  wire logic       hold,
   // result
   output logic            busy,
   output logic            done
);
   logic [5:0] cnt_q;

   always_ff @(posedge sys_clk) begin
      if (reset) begin
         cnt_q <= 6'h00;
         busy  <= 1'b0;
         done  <= 1'b0;
      end else begin
         // done waits out a suspend so the core cannot miss it
         done <= done && hold;
         if (start) begin
            cnt_q <= len - 6'h01;
            busy  <= 1'b1;
         end else if (busy && !hold) begin
            if (cnt_q == 6'h01) begin
               busy <= 1'b0;
               done <= 1'b1;
            end
            cnt_q <= cnt_q - 6'h01;
         end
      end
   end
endmodule

// ===== bench/dmati_chan_model.sv
`timescale 1ns/100ps
// ==========================================================
// serial channel stand-in: asks for data cycles, marks frame ends
module dmati_chan_model
   import dmati_pkg::*;
(
   // clock and reset
   input  wire logic        sys_clk,
   input  wire logic        reset,
   // bench control
   input  wire logic        req_on,
   input  wire logic [3:0]  frame_len,
   input  wire logic        last,
   // design side
   input  wire logic        mem_cycle,
   output dmati_chan_t      chan
);
   logic [3:0] cnt_q;
   logic       wrap;

   // dropping the request restarts framing, so scenarios start clean
   always_ff @(posedge sys_clk) begin
      if (reset || !req_on) begin
         cnt_q <= 4'h0;
      end else if (mem_cycle) begin
         cnt_q <= wrap ? 4'h0 : cnt_q + 4'h1;
      end
   end

   assign wrap           = (cnt_q + 4'h1 >= frame_len);
   assign chan.xfer_req  = req_on;
   assign chan.frame_end = wrap;
   assign chan.last_buf  = last;
endmodule

// ===== bench/dmati_test.sv
`timescale 1ns/100ps
module dmati_test
   import dmati_pkg::*;
;
   logic        sys_clk, reset, req_on, last;
   logic [3:0]  frame_len;
   dmati_bus_t  bus;
   dmati_chan_t chan;
   logic [7:0]  rdata;
   logic        mem_cycle, xfer_done, dma_error_irq, dma_normal_end_irq;
   logic [1:0]  chan_prio;
   int          n_fail, n_checks, cyc, lat0, t0;
   int          mc_t[$];
   bit          done_seen;
   logic [5:0]  su_t [4] = '{DMATI_TX_SETUP_W, DMATI_RX_SETUP_W, DMATI_TX_SETUP_B, DMATI_RX_SETUP_B};
   logic [5:0]  sw1_t [4] = '{DMATI_TX_SW_MID_W, DMATI_RX_SW_W, DMATI_TX_SW_MID_B, DMATI_RX_SW_B};
   logic [5:0]  sw2_t [4] = '{DMATI_TX_SW_END_W, DMATI_RX_SW_W, DMATI_TX_SW_END_B, DMATI_RX_SW_B};

   dmati_core dmati_core_i (.sys_clk(sys_clk), .reset(reset), .bus(bus), .rdata(rdata), .chan(chan),
      .mem_cycle(mem_cycle), .xfer_done(xfer_done), .chan_prio(chan_prio),
      .dma_error_irq(dma_error_irq), .dma_normal_end_irq(dma_normal_end_irq));
   dmati_chan_model dmati_chan_model_i (.sys_clk(sys_clk), .reset(reset), .req_on(req_on),
      .frame_len(frame_len), .last(last), .mem_cycle(mem_cycle), .chan(chan));

   // ==========================================================
   // clock, event log, watchdog
   initial begin
      sys_clk = 1'b0;
      forever #2.5 sys_clk = ~sys_clk;
   end
   always @(posedge sys_clk) begin
      cyc <= cyc + 1;
      if (mem_cycle === 1'b1) mc_t.push_back(cyc);
      if (xfer_done === 1'b1) done_seen = 1'b1;
   end
   initial begin
      #100000;
      n_fail++;
      conclude();
   end

   // ==========================================================
   // shared tasks
   task check(input logic [15:0] got, input logic [15:0] exp);
      n_checks++;
      if (got !== exp) begin
         n_fail++;
         $display("[FAIL] t=%0t got=%0h exp=%0h", $time, got, exp);
      end
   endtask
   task wr(input logic [3:0] a, input logic [7:0] d);
      @(posedge sys_clk);
      bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
      @(posedge sys_clk);
      bus.wr <= 1'b0;
      t0 = cyc;
   endtask
   task rd(input logic [3:0] a, input logic [7:0] m, input logic [7:0] e);
      @(posedge sys_clk);
      bus <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
      @(posedge sys_clk);
      bus.rd <= 1'b0;
      @(posedge sys_clk);
      check({8'h00, rdata & m}, {8'h00, e});
   endtask
   task wait_mc(input int n);
      for (int i = 0; i < 3000 && mc_t.size() < n; i++) @(posedge sys_clk);
      if (mc_t.size() < n) begin
         n_fail++;
         $display("[FAIL] t=%0t got=%0h exp=%0h", $time, mc_t.size(), n);
      end
   endtask
   // suspend, abort and clear before programming: idle only
   task setup(input logic [7:0] ctrl, mode, bfl, eda, ie, input logic [3:0] fl);
      req_on <= 1'b0;
      wr(DMATI_ADDR_STATUS, 8'h01);
      wr(DMATI_ADDR_COMMAND, DMATI_CMD_ABORT);
      wr(DMATI_ADDR_STATUS, 8'hF0);
      wr(DMATI_ADDR_CTRL, ctrl);
      wr(DMATI_ADDR_MODE, mode);
      wr(DMATI_ADDR_BFL, bfl);
      wr(DMATI_ADDR_CDA, 8'h00);
      wr(DMATI_ADDR_EDA, eda);
      wr(DMATI_ADDR_IRQ_EN, ie);
      frame_len <= fl;
      req_on    <= 1'b1;
      mc_t.delete();
      done_seen = 1'b0;
   endtask

   // ==========================================================
   // scenarios
   task t_reset;
      rd(DMATI_ADDR_STATUS, 8'hFF, 8'h00);
      rd(DMATI_ADDR_IRQ_EN, 8'hFF, 8'h00);
      rd(DMATI_ADDR_MODE, 8'hFF, 8'h00);
      rd(DMATI_ADDR_FCT, 8'hFF, 8'h00);
      rd(4'h9, 8'hFF, 8'h00);
      check(16'(chan_prio), 16'(DMATI_PRIO_RESET));
      check(16'({dma_error_irq, dma_normal_end_irq}), 16'h0000);
   endtask
   task t_single;
      setup(8'h00, 8'h00, 8'h02, 8'h01, 8'h80, 4'h4);
      wr(DMATI_ADDR_STATUS, 8'h03);
      wait_mc(2);
      lat0 = mc_t[0] - t0;
      check(16'(mc_t[1] - mc_t[0]), 16'(DMATI_XFER_STATES));
      for (int i = 0; i < 200 && dma_normal_end_irq !== 1'b1; i++) @(posedge sys_clk);
      check(16'(done_seen), 16'h0001);
      rd(DMATI_ADDR_STATUS, 8'hF2, 8'h80);
      req_on <= 1'b0;
      repeat (20) @(posedge sys_clk);
      check(16'(dma_normal_end_irq), 16'h0001);
      wr(DMATI_ADDR_IRQ_EN, 8'h00);
      repeat (3) @(posedge sys_clk);
      check(16'(dma_normal_end_irq), 16'h0000);
      wr(DMATI_ADDR_IRQ_EN, 8'h80);
      repeat (3) @(posedge sys_clk);
      check(16'(dma_normal_end_irq), 16'h0001);
      wr(DMATI_ADDR_STATUS, 8'h80);
      repeat (3) @(posedge sys_clk);
      check(16'(dma_normal_end_irq), 16'h0000);
   endtask
   // one pass per bus width and direction; the single-block lead-in is the reference
   task t_chained;
      for (int i = 0; i < 4; i++) begin
         setup(8'((i % 2) * 4 + i / 2), 8'h14, 8'h01, 8'h80, 8'h40, 4'h2);
         wr(DMATI_ADDR_STATUS, 8'h03);
         wait_mc(3);
         check(16'(mc_t[0] - t0 - lat0), 16'(su_t[i]));
         check(16'(mc_t[1] - mc_t[0] - 3), 16'(sw1_t[i]));
         check(16'(mc_t[2] - mc_t[1] - 3), 16'(sw2_t[i]));
         check(16'(done_seen), 16'h0000);
         rd(DMATI_ADDR_STATUS, 8'h42, 8'h42);
         check(16'(dma_normal_end_irq), 16'h0001);
      end
   endtask
   task t_counter;
      setup(8'h00, 8'h16, 8'h01, 8'h80, 8'h10, 4'h1);
      wr(DMATI_ADDR_STATUS, 8'h03);
      wait_mc(15);
      repeat (2) @(posedge sys_clk);
      wr(DMATI_ADDR_STATUS, 8'h01);
      repeat (60) @(posedge sys_clk);
      check(16'(mc_t.size()), 16'd15);
      rd(DMATI_ADDR_FCT, 8'hFF, 8'h0F);
      wr(DMATI_ADDR_STATUS, 8'h40);
      rd(DMATI_ADDR_STATUS, 8'h40, 8'h40);
      wr(DMATI_ADDR_COMMAND, DMATI_CMD_FCT_CLEAR);
      rd(DMATI_ADDR_FCT, 8'hFF, 8'h0E);
      wr(DMATI_ADDR_STATUS, 8'h03);
      wait_mc(17);
      repeat (10) @(posedge sys_clk);
      wr(DMATI_ADDR_STATUS, 8'h01);
      rd(DMATI_ADDR_FCT, 8'hFF, 8'h00);
      rd(DMATI_ADDR_STATUS, 8'h10, 8'h10);
      check(16'(dma_error_irq), 16'h0001);
      wr(DMATI_ADDR_STATUS, 8'h10);
      repeat (3) @(posedge sys_clk);
      check(16'(dma_error_irq), 16'h0000);
   endtask
   task t_overrun;
      setup(8'h04, 8'h14, 8'h01, 8'h01, 8'h20, 4'h4);
      wr(DMATI_ADDR_STATUS, 8'h03);
      for (int i = 0; i < 300 && dma_error_irq !== 1'b1; i++) @(posedge sys_clk);
      check(16'(dma_error_irq), 16'h0001);
      req_on <= 1'b0;
      wr(DMATI_ADDR_STATUS, 8'h01);
      rd(DMATI_ADDR_STATUS, 8'h20, 8'h20);
      wr(DMATI_ADDR_STATUS, 8'h20);
      repeat (3) @(posedge sys_clk);
      check(16'(dma_error_irq), 16'h0000);
   endtask

   // ==========================================================
   // main sequence and verdict
   task conclude;
      $display("checks=%0d failures=%0d", n_checks, n_fail);
      if (n_fail == 0 && n_checks > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask
   initial begin
      bus       = '0;
      req_on    = 1'b0;
      last      = 1'b0;
      frame_len = 4'h1;
      reset     = 1'b1;
      cyc       = 0;
      n_fail    = 0;
      n_checks  = 0;
      repeat (4) @(posedge sys_clk);
      reset <= 1'b0;
      t_reset();
      t_single();
      t_chained();
      t_counter();
      t_overrun();
      conclude();
   end
endmodule
